// ### core/icd_map.svh
// Constants for the instruction cycle decoder
`ifndef ICD_MAP_SVH
`define ICD_MAP_SVH

// Word and field geometry
`define ICD_WORD_W        14
`define ICD_FADDR_LSB     0
`define ICD_FADDR_W       7
`define ICD_DEST_BIT      7
`define ICD_BITNUM_LSB    7
`define ICD_BITNUM_W      3
`define ICD_LIT8_W        8
`define ICD_LIT11_W       11
`define ICD_MODE_LSB      0
`define ICD_MODE_W        2
`define ICD_PTR_MISC_BIT  2
`define ICD_PTR_OFS_BIT   6
`define ICD_STORE_MISC_BIT 3
`define ICD_STORE_OFS_BIT 7

// Indirect access port addresses, one per pointer
`define ICD_PORT0_ADDR    7'h00
`define ICD_PORT1_ADDR    7'h01
`define ICD_FADDR_MAX     7'h7F

// Timing
`define ICD_PHASES        4
`define ICD_PHASE_READ    2'h1
`define ICD_PHASE_LAST    2'h3
`define ICD_PHASE_RESET   2'h3
`define ICD_CYC_SINGLE    2'h1
`define ICD_CYC_DOUBLE    2'h2

// Opcode patterns, don't-care bits left open
`define ICD_PAT_EXIT_SUB  14'b00_0000_0000_1000
`define ICD_PAT_EXIT_INT  14'b00_0000_0000_1001
`define ICD_PAT_INV_ACC   14'b00_0000_0000_1010
`define ICD_PAT_JMP_ACC   14'b00_0000_0000_1011
`define ICD_PAT_IND_MISC  14'b00_0000_0001_????
`define ICD_PAT_CTRL      14'b00_0000_0???_????
`define ICD_PAT_DEC_SKIP  14'b00_1011_????_????
`define ICD_PAT_INC_SKIP  14'b00_1111_????_????
`define ICD_PAT_BYTE      14'b00_????_????_????
`define ICD_PAT_SKIP_BIT  14'b01_1???_????_????
`define ICD_PAT_BIT       14'b01_0???_????_????
`define ICD_PAT_INV_LIT   14'b10_0???_????_????
`define ICD_PAT_JMP_ABS   14'b10_1???_????_????
`define ICD_PAT_EXIT_LIT  14'b11_0100_????_????
`define ICD_PAT_JMP_REL   14'b11_001?_????_????
`define ICD_PAT_PTR_LIT   14'b11_0001_????_????
`define ICD_PAT_IND_OFS   14'b11_1111_????_????
`define ICD_PAT_SHIFT     14'b11_01??_????_????
`define ICD_PAT_CARRY_A   14'b11_1011_????_????
`define ICD_PAT_CARRY_B   14'b11_1101_????_????
`define ICD_PAT_LIT       14'b11_????_????_????

`endif

// ### core/icd_pkg.sv
// Types for the instruction cycle decoder
package icd_pkg;

  typedef enum logic [3:0] {
    icd_cls_control,
    icd_cls_byte,
    icd_cls_bit,
    icd_cls_skip_bit,
    icd_cls_skip_count,
    icd_cls_literal,
    icd_cls_invoke,
    icd_cls_exit,
    icd_cls_jump,
    icd_cls_indirect_move
  } icd_class_t;

  typedef enum logic [1:0] {
    icd_mode_pre_inc,
    icd_mode_pre_dec,
    icd_mode_post_inc,
    icd_mode_post_dec
  } icd_ptr_mode_t;

  typedef enum logic {
    icd_seq_idle,
    icd_seq_run
  } icd_seq_t;

endpackage

// ### core/icd_field_split.sv
// Operand field extraction from one instruction word
`timescale 1ns/1ps
`include "icd_map.svh"

module icd_field_split (
  instr_word,
  file_addr,
  dest_file,
  bit_num,
  lit8,
  lit11,
  ptr_mode,
  port_ref,
  port_ptr
);
  input  wire logic [`ICD_WORD_W-1:0]  instr_word;
  output logic [`ICD_FADDR_W-1:0]      file_addr;
  output logic                         dest_file;
  output logic [`ICD_BITNUM_W-1:0]     bit_num;
  output logic [`ICD_LIT8_W-1:0]       lit8;
  output logic [`ICD_LIT11_W-1:0]      lit11;
  output icd_pkg::icd_ptr_mode_t       ptr_mode;
  output logic                         port_ref;
  output logic                         port_ptr;

  always_comb begin
    file_addr = instr_word[`ICD_FADDR_LSB +: `ICD_FADDR_W];
    dest_file = instr_word[`ICD_DEST_BIT];
    bit_num   = instr_word[`ICD_BITNUM_LSB +: `ICD_BITNUM_W];
    lit8      = instr_word[`ICD_LIT8_W-1:0];
    lit11     = instr_word[`ICD_LIT11_W-1:0];
    ptr_mode  = icd_pkg::icd_ptr_mode_t'(instr_word[`ICD_MODE_LSB +: `ICD_MODE_W]);
    port_ref  = (file_addr == `ICD_PORT0_ADDR) || (file_addr == `ICD_PORT1_ADDR);
    port_ptr  = file_addr[0];
    casez (instr_word)
      `ICD_PAT_IND_MISC: begin
        port_ptr = instr_word[`ICD_PTR_MISC_BIT];
      end
      `ICD_PAT_IND_OFS: begin
        port_ptr = instr_word[`ICD_PTR_OFS_BIT];
      end
      default: begin
        port_ptr = file_addr[0];
      end
    endcase
  end

endmodule

// ### core/icd_decode.sv
// Instruction classifier and four-phase cycle sequencer
`timescale 1ns/1ps
`include "icd_map.svh"

// Function
// - One 14-bit word holds opcode and operands
// - Ordinary instructions finish in one cycle
// - Both subroutine invokes take two cycles
// - All three exits take two cycles
// - Jumps take two cycles, skips two only when the skip is taken
// - Indirect port on program memory adds cycle
// - Each cycle is four oscillator clocks
// - File operand read, modified, then written
// - File read happens even for write-only, except indirect moves (loads and stores)
// - File address covers 0x00 to 0x7F
// - Destination bit picks accumulator or file
// - Bit field picks one of eight bits
// - Pointer field picks pointer 0 or 1
// - Mode field picks pre/post inc/dec
// - Don't-care bits never change execution
module icd_decode (
  sys_clk,
  reset,
  instr_word,
  instr_valid,
  ptr_in_prog,
  skip_taken,
  instr_ready,
  phase,
  cycle_start,
  busy,
  first_cycle,
  flush_cycle,
  instr_class,
  file_addr,
  dest_file,
  bit_num,
  lit8,
  lit11,
  ptr_sel,
  ptr_mode,
  indirect_prog,
  cycles_total,
  file_read_stb,
  file_write_stb,
  acc_write_stb,
  ptr_adjust_stb
);
  input  wire logic                    sys_clk;
  input  wire logic                    reset;
  input  wire logic [`ICD_WORD_W-1:0]  instr_word;
  input  wire logic                    instr_valid;
  input  wire logic [1:0]              ptr_in_prog;
  input  wire logic                    skip_taken;
  output logic                         instr_ready;
  output logic [1:0]                   phase;
  output logic                         cycle_start;
  output logic                         busy;
  output logic                         first_cycle;
  output logic                         flush_cycle;
  output icd_pkg::icd_class_t          instr_class;
  output logic [`ICD_FADDR_W-1:0]      file_addr;
  output logic                         dest_file;
  output logic [`ICD_BITNUM_W-1:0]     bit_num;
  output logic [`ICD_LIT8_W-1:0]       lit8;
  output logic [`ICD_LIT11_W-1:0]      lit11;
  output logic                         ptr_sel;
  output icd_pkg::icd_ptr_mode_t       ptr_mode;
  output logic                         indirect_prog;
  output logic [1:0]                   cycles_total;
  output logic                         file_read_stb;
  output logic                         file_write_stb;
  output logic                         acc_write_stb;
  output logic                         ptr_adjust_stb;

  // Classify by opcode; open pattern bits make don't-care bits inert
  function automatic icd_pkg::icd_class_t icd_classify(
    input logic [`ICD_WORD_W-1:0] w
  );
    icd_pkg::icd_class_t c;
    c = icd_pkg::icd_cls_literal;
    casez (w)
      `ICD_PAT_EXIT_SUB: c = icd_pkg::icd_cls_exit;
      `ICD_PAT_EXIT_INT: c = icd_pkg::icd_cls_exit;
      `ICD_PAT_INV_ACC:  c = icd_pkg::icd_cls_invoke;
      `ICD_PAT_JMP_ACC:  c = icd_pkg::icd_cls_jump;
      `ICD_PAT_IND_MISC: c = icd_pkg::icd_cls_indirect_move;
      `ICD_PAT_CTRL:     c = icd_pkg::icd_cls_control;
      `ICD_PAT_DEC_SKIP: c = icd_pkg::icd_cls_skip_count;
      `ICD_PAT_INC_SKIP: c = icd_pkg::icd_cls_skip_count;
      `ICD_PAT_BYTE:     c = icd_pkg::icd_cls_byte;
      `ICD_PAT_SKIP_BIT: c = icd_pkg::icd_cls_skip_bit;
      `ICD_PAT_BIT:      c = icd_pkg::icd_cls_bit;
      `ICD_PAT_INV_LIT:  c = icd_pkg::icd_cls_invoke;
      `ICD_PAT_JMP_ABS:  c = icd_pkg::icd_cls_jump;
      `ICD_PAT_EXIT_LIT: c = icd_pkg::icd_cls_exit;
      `ICD_PAT_JMP_REL:  c = icd_pkg::icd_cls_jump;
      `ICD_PAT_PTR_LIT:  c = icd_pkg::icd_cls_control;
      `ICD_PAT_IND_OFS:  c = icd_pkg::icd_cls_indirect_move;
      `ICD_PAT_SHIFT:    c = icd_pkg::icd_cls_byte;
      `ICD_PAT_CARRY_A:  c = icd_pkg::icd_cls_byte;
      `ICD_PAT_CARRY_B:  c = icd_pkg::icd_cls_byte;
      `ICD_PAT_LIT:      c = icd_pkg::icd_cls_literal;
      default:           c = icd_pkg::icd_cls_control;
    endcase
    return c;
  endfunction

  // Cycle count before any skip decision
  function automatic logic [1:0] icd_base_cycles(
    input icd_pkg::icd_class_t c
  );
    logic [1:0] n;
    n = `ICD_CYC_SINGLE;
    case (c)
      icd_pkg::icd_cls_invoke: n = `ICD_CYC_DOUBLE;
      icd_pkg::icd_cls_exit:   n = `ICD_CYC_DOUBLE;
      icd_pkg::icd_cls_jump:   n = `ICD_CYC_DOUBLE;
      default:                 n = `ICD_CYC_SINGLE;
    endcase
    return n;
  endfunction

  // Whether the class carries a file-register operand
  function automatic logic icd_has_file(
    input icd_pkg::icd_class_t c
  );
    return (c == icd_pkg::icd_cls_byte) || (c == icd_pkg::icd_cls_bit) ||
           (c == icd_pkg::icd_cls_skip_bit) || (c == icd_pkg::icd_cls_skip_count);
  endfunction

  logic [`ICD_FADDR_W-1:0]  sp_file_addr;
  logic                     sp_dest_file;
  logic [`ICD_BITNUM_W-1:0] sp_bit_num;
  logic [`ICD_LIT8_W-1:0]   sp_lit8;
  logic [`ICD_LIT11_W-1:0]  sp_lit11;
  icd_pkg::icd_ptr_mode_t   sp_ptr_mode;
  logic                     sp_port_ref;
  logic                     sp_port_ptr;

  icd_field_split u_split (
    .instr_word (instr_word),
    .file_addr  (sp_file_addr),
    .dest_file  (sp_dest_file),
    .bit_num    (sp_bit_num),
    .lit8       (sp_lit8),
    .lit11      (sp_lit11),
    .ptr_mode   (sp_ptr_mode),
    .port_ref   (sp_port_ref),
    .port_ptr   (sp_port_ptr)
  );

  // Sequencer state
  logic [1:0]               phase_q;
  logic [1:0]               phase_d;
  icd_pkg::icd_seq_t        seq_q;
  icd_pkg::icd_seq_t        seq_d;
  logic [1:0]               remain_q;
  logic [1:0]               remain_d;
  logic                     first_q;
  logic                     first_d;
  logic                     flush_q;
  logic                     flush_d;
  logic [1:0]               total_q;
  logic [1:0]               total_d;

  // Latched instruction
  icd_pkg::icd_class_t      class_q;
  icd_pkg::icd_class_t      class_d;
  logic [`ICD_FADDR_W-1:0]  faddr_q;
  logic [`ICD_FADDR_W-1:0]  faddr_d;
  logic                     dest_q;
  logic                     dest_d;
  logic [`ICD_BITNUM_W-1:0] bitn_q;
  logic [`ICD_BITNUM_W-1:0] bitn_d;
  logic [`ICD_LIT8_W-1:0]   lit8_q;
  logic [`ICD_LIT8_W-1:0]   lit8_d;
  logic [`ICD_LIT11_W-1:0]  lit11_q;
  logic [`ICD_LIT11_W-1:0]  lit11_d;
  logic                     ptr_q;
  logic                     ptr_d;
  icd_pkg::icd_ptr_mode_t   mode_q;
  icd_pkg::icd_ptr_mode_t   mode_d;
  logic                     indp_q;
  logic                     indp_d;
  logic                     store_q;
  logic                     store_d;

  logic                     end_cycle;
  logic                     accept;
  logic                     skip_extra;
  logic [1:0]               owed;
  icd_pkg::icd_class_t      new_class;
  logic                     new_port;
  logic                     new_indp;
  logic [1:0]               new_cycles;

  assign end_cycle   = (phase_q == `ICD_PHASE_LAST);
  assign new_class   = icd_classify(instr_word);
  assign new_port    = (new_class == icd_pkg::icd_cls_indirect_move) ||
                       (icd_has_file(new_class) && sp_port_ref);
  assign new_indp    = new_port && ptr_in_prog[sp_port_ptr];
  assign new_cycles  = icd_base_cycles(new_class) + {1'b0, new_indp};
  // Skip costs its second cycle only if taken, decided at end of cycle one
  assign skip_extra  = first_q && (seq_q == icd_pkg::icd_seq_run) &&
                       ((class_q == icd_pkg::icd_cls_skip_bit) ||
                        (class_q == icd_pkg::icd_cls_skip_count)) && skip_taken;
  assign owed        = remain_q + {1'b0, skip_extra};
  assign instr_ready = end_cycle && (owed == 2'h0);
  assign accept      = instr_ready && instr_valid;

  always_comb begin
    phase_d  = phase_q + 2'h1;
    seq_d    = seq_q;
    remain_d = remain_q;
    first_d  = first_q;
    flush_d  = flush_q;
    total_d  = total_q;
    class_d  = class_q;
    faddr_d  = faddr_q;
    dest_d   = dest_q;
    bitn_d   = bitn_q;
    lit8_d   = lit8_q;
    lit11_d  = lit11_q;
    ptr_d    = ptr_q;
    mode_d   = mode_q;
    indp_d   = indp_q;
    store_d  = store_q;
    if (end_cycle) begin
      if (owed != 2'h0) begin
        remain_d = owed - 2'h1;
        first_d  = 1'b0;
        flush_d  = 1'b1;
        if (skip_extra) begin
          total_d = total_q + 2'h1;
        end
      end else if (accept) begin
        seq_d    = icd_pkg::icd_seq_run;
        remain_d = new_cycles - 2'h1;
        first_d  = 1'b1;
        flush_d  = 1'b0;
        total_d  = new_cycles;
        class_d  = new_class;
        faddr_d  = sp_file_addr;
        dest_d   = sp_dest_file;
        bitn_d   = sp_bit_num;
        lit8_d   = sp_lit8;
        lit11_d  = sp_lit11;
        ptr_d    = sp_port_ptr;
        mode_d   = sp_ptr_mode;
        indp_d   = new_indp;
        store_d  = (new_class == icd_pkg::icd_cls_indirect_move) &&
                   (instr_word[13] ? instr_word[`ICD_STORE_OFS_BIT]
                                   : instr_word[`ICD_STORE_MISC_BIT]);
      end else begin
        seq_d   = icd_pkg::icd_seq_idle;
        first_d = 1'b0;
        flush_d = 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      phase_q  <= `ICD_PHASE_RESET;
      seq_q    <= icd_pkg::icd_seq_idle;
      remain_q <= 2'h0;
      first_q  <= 1'b0;
      flush_q  <= 1'b0;
      total_q  <= 2'h0;
    end else begin
      phase_q  <= phase_d;
      seq_q    <= seq_d;
      remain_q <= remain_d;
      first_q  <= first_d;
      flush_q  <= flush_d;
      total_q  <= total_d;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      class_q <= icd_pkg::icd_cls_control;
      faddr_q <= 7'h00;
      dest_q  <= 1'b0;
      bitn_q  <= 3'h0;
      lit8_q  <= 8'h00;
      lit11_q <= 11'h000;
      ptr_q   <= 1'b0;
      mode_q  <= icd_pkg::icd_mode_pre_inc;
      indp_q  <= 1'b0;
      store_q <= 1'b0;
    end else begin
      class_q <= class_d;
      faddr_q <= faddr_d;
      dest_q  <= dest_d;
      bitn_q  <= bitn_d;
      lit8_q  <= lit8_d;
      lit11_q <= lit11_d;
      ptr_q   <= ptr_d;
      mode_q  <= mode_d;
      indp_q  <= indp_d;
      store_q <= store_d;
    end
  end

  logic run_first;
  logic has_file;
  logic byte_like;

  assign run_first = (seq_q == icd_pkg::icd_seq_run) && first_q;
  assign has_file  = icd_has_file(class_q);
  assign byte_like = (class_q == icd_pkg::icd_cls_byte) ||
                     (class_q == icd_pkg::icd_cls_skip_count);

  assign phase         = phase_q;
  assign cycle_start   = (phase_q == 2'h0);
  assign busy          = (seq_q == icd_pkg::icd_seq_run);
  assign first_cycle   = run_first;
  assign flush_cycle   = flush_q;
  assign instr_class   = class_q;
  assign file_addr     = faddr_q;
  assign dest_file     = dest_q;
  assign bit_num       = bitn_q;
  assign lit8          = lit8_q;
  assign lit11         = lit11_q;
  assign ptr_sel       = ptr_q;
  assign ptr_mode      = mode_q;
  assign indirect_prog = indp_q;
  assign cycles_total  = total_q;
  // Read in the second phase for file-operand classes only, write in the last phase
  assign file_read_stb  = run_first && (phase_q == `ICD_PHASE_READ) && has_file;
  assign file_write_stb = run_first && end_cycle &&
                          ((byte_like && dest_q) ||
                           (class_q == icd_pkg::icd_cls_bit) ||
                           (class_q == icd_pkg::icd_cls_indirect_move && store_q));
  assign acc_write_stb  = run_first && end_cycle &&
                          ((byte_like && !dest_q) ||
                           (class_q == icd_pkg::icd_cls_literal) ||
                           (class_q == icd_pkg::icd_cls_exit) ||
                           (class_q == icd_pkg::icd_cls_indirect_move && !store_q));
  assign ptr_adjust_stb = run_first && end_cycle &&
                          (class_q == icd_pkg::icd_cls_indirect_move);

endmodule

// ### verification/icd_decode_assertions.sv
// Port-level timing checks for the instruction cycle decoder
`timescale 1ns/1ps
module icd_decode_assertions (
  sys_clk,
  reset,
  instr_valid,
  skip_taken,
  instr_ready,
  phase,
  busy,
  first_cycle,
  flush_cycle,
  instr_class,
  file_addr,
  lit11,
  indirect_prog,
  cycles_total,
  file_read_stb,
  file_write_stb,
  acc_write_stb
);
  input wire logic                 sys_clk;
  input wire logic                 reset;
  input wire logic                 instr_valid;
  input wire logic                 skip_taken;
  input wire logic                 instr_ready;
  input wire logic [1:0]           phase;
  input wire logic                 busy;
  input wire logic                 first_cycle;
  input wire logic                 flush_cycle;
  input wire icd_pkg::icd_class_t  instr_class;
  input wire logic [6:0]           file_addr;
  input wire logic [10:0]          lit11;
  input wire logic                 indirect_prog;
  input wire logic [1:0]           cycles_total;
  input wire logic                 file_read_stb;
  input wire logic                 file_write_stb;
  input wire logic                 acc_write_stb;
  logic skip_cls;
  logic two_cls;
  logic last_q1;
  assign skip_cls = instr_class inside {icd_pkg::icd_cls_skip_bit, icd_pkg::icd_cls_skip_count};
  assign two_cls  = instr_class inside {icd_pkg::icd_cls_invoke, icd_pkg::icd_cls_exit,
                                        icd_pkg::icd_cls_jump};
  assign last_q1  = first_cycle && phase == 2'h3;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  property p_phase_step; busy && phase != 2'h3 |=> phase == $past(phase) + 2'h1; endproperty
  a_phase_step: assert property (p_phase_step) else $error("phase did not advance");
  property p_ready_phase; instr_ready |-> phase == 2'h3; endproperty
  a_ready_phase: assert property (p_ready_phase) else $error("ready outside last phase");
  property p_accept; instr_ready && instr_valid |=> busy && first_cycle && phase == 2'h0; endproperty
  a_accept: assert property (p_accept) else $error("accepted word did not start");
  property p_read_slot; file_read_stb |-> first_cycle && phase == 2'h1; endproperty
  a_read_slot: assert property (p_read_slot) else $error("file read out of slot");
  property p_read_first;
    file_write_stb && instr_class != icd_pkg::icd_cls_indirect_move |-> $past(file_read_stb, 2);
  endproperty
  a_read_first: assert property (p_read_first) else $error("file write without read");
  property p_single; last_q1 && cycles_total == 2'h1 && !skip_cls |-> instr_ready; endproperty
  a_single: assert property (p_single) else $error("single cycle overran");
  property p_skip; last_q1 && skip_cls |-> instr_ready == (!skip_taken && !indirect_prog); endproperty
  a_skip: assert property (p_skip) else $error("skip cycle choice wrong");
  property p_two; last_q1 && two_cls |-> !instr_ready ##4 instr_ready == !indirect_prog; endproperty
  a_two: assert property (p_two) else $error("flow change not two cycles");
  property p_extra; last_q1 && indirect_prog && !skip_cls |-> !instr_ready; endproperty
  a_extra: assert property (p_extra) else $error("no extra indirect cycle");
  property p_flush; last_q1 && !instr_ready |=> flush_cycle [*4]; endproperty
  a_flush: assert property (p_flush) else $error("extra cycle not flagged");
  property p_write_slot;
    acc_write_stb || file_write_stb |-> last_q1 && !(acc_write_stb && file_write_stb);
  endproperty
  a_write_slot: assert property (p_write_slot) else $error("write slot wrong");
  property p_hold;
    busy && !instr_ready |=> $stable(file_addr) && $stable(lit11) && $stable(instr_class);
  endproperty
  a_hold: assert property (p_hold) else $error("fields moved mid instruction");
endmodule

bind icd_decode icd_decode_assertions i_icd_decode_assertions (.sys_clk, .reset, .instr_valid,
  .skip_taken, .instr_ready, .phase, .busy, .first_cycle, .flush_cycle, .instr_class, .file_addr,
  .lit11, .indirect_prog, .cycles_total, .file_read_stb, .file_write_stb, .acc_write_stb);

// ### verification/tb.sv
// Self-checking bench for the instruction cycle decoder
`timescale 1ns/1ps
`include "icd_map.svh"
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_errors++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module tb;
  logic                sys_clk, reset, instr_valid, skip_taken, instr_ready, cycle_start, busy;
  logic                first_cycle, flush_cycle, dest_file, ptr_sel, indirect_prog;
  logic                file_read_stb, file_write_stb, acc_write_stb, ptr_adjust_stb;
  logic [13:0]         instr_word;
  logic [1:0]          ptr_in_prog, phase, cycles_total;
  logic [6:0]          file_addr;
  logic [2:0]          bit_num;
  logic [7:0]          lit8;
  logic [10:0]         lit11;
  icd_pkg::icd_class_t instr_class;
  icd_pkg::icd_ptr_mode_t ptr_mode;
  int                  n_errors, compares, i;
  logic [31:0]         rng;
  logic [13:0]         dirs [18] = '{14'h0008, 14'h0009, 14'h000A, 14'h000B, 14'h0000, 14'h0012,
    14'h001F, 14'h2800, 14'h2000, 14'h3400, 14'h3200, 14'h3F85, 14'h0B00, 14'h0F81, 14'h1800,
    14'h1C01, 14'h1080, 14'h0880};
  icd_decode i_icd_decode (.sys_clk(sys_clk), .reset(reset), .instr_word(instr_word),
    .instr_valid(instr_valid), .ptr_in_prog(ptr_in_prog), .skip_taken(skip_taken),
    .instr_ready(instr_ready), .phase(phase), .cycle_start(cycle_start), .busy(busy),
    .first_cycle(first_cycle), .flush_cycle(flush_cycle), .instr_class(instr_class),
    .file_addr(file_addr), .dest_file(dest_file), .bit_num(bit_num), .lit8(lit8), .lit11(lit11),
    .ptr_sel(ptr_sel), .ptr_mode(ptr_mode), .indirect_prog(indirect_prog),
    .cycles_total(cycles_total), .file_read_stb(file_read_stb), .file_write_stb(file_write_stb),
    .acc_write_stb(acc_write_stb), .ptr_adjust_stb(ptr_adjust_stb));
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction
  function automatic icd_pkg::icd_class_t m_cls(input logic [13:0] w);
    casez (w)
      `ICD_PAT_EXIT_SUB, `ICD_PAT_EXIT_INT: return icd_pkg::icd_cls_exit;
      `ICD_PAT_INV_ACC: return icd_pkg::icd_cls_invoke;
      `ICD_PAT_JMP_ACC: return icd_pkg::icd_cls_jump;
      `ICD_PAT_IND_MISC: return icd_pkg::icd_cls_indirect_move;
      `ICD_PAT_CTRL: return icd_pkg::icd_cls_control;
      `ICD_PAT_DEC_SKIP, `ICD_PAT_INC_SKIP: return icd_pkg::icd_cls_skip_count;
      `ICD_PAT_BYTE: return icd_pkg::icd_cls_byte;
      `ICD_PAT_SKIP_BIT: return icd_pkg::icd_cls_skip_bit;
      `ICD_PAT_BIT: return icd_pkg::icd_cls_bit;
      `ICD_PAT_INV_LIT: return icd_pkg::icd_cls_invoke;
      `ICD_PAT_JMP_ABS: return icd_pkg::icd_cls_jump;
      `ICD_PAT_EXIT_LIT: return icd_pkg::icd_cls_exit;
      `ICD_PAT_JMP_REL: return icd_pkg::icd_cls_jump;
      `ICD_PAT_PTR_LIT: return icd_pkg::icd_cls_control;
      `ICD_PAT_IND_OFS: return icd_pkg::icd_cls_indirect_move;
      `ICD_PAT_SHIFT, `ICD_PAT_CARRY_A, `ICD_PAT_CARRY_B: return icd_pkg::icd_cls_byte;
      default: return icd_pkg::icd_cls_literal;
    endcase
  endfunction
  task automatic tally_and_finish();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Junk words and random skip flags are offered every clock; words must be ignored, skip_taken decides skips
  task automatic run_one(input logic [13:0] w, input logic [1:0] p);
    icd_pkg::icd_class_t c;
    logic fc, bc, sk, ir, ip, pt, st, dd;
    logic [31:0] r;
    int cyc, n;
    c = m_cls(w);
    fc = c inside {icd_pkg::icd_cls_byte, icd_pkg::icd_cls_bit, icd_pkg::icd_cls_skip_bit,
                   icd_pkg::icd_cls_skip_count};
    bc = c inside {icd_pkg::icd_cls_byte, icd_pkg::icd_cls_skip_count};
    sk = c inside {icd_pkg::icd_cls_skip_bit, icd_pkg::icd_cls_skip_count};
    ir = (fc && w[6:1] == 6'h00) || c == icd_pkg::icd_cls_indirect_move;
    pt = (c == icd_pkg::icd_cls_indirect_move) ? (w[13] ? w[6] : w[2]) : w[0];
    st = w[13] ? w[7] : w[3];
    ip = ir && p[pt];
    cyc = ((c inside {icd_pkg::icd_cls_invoke, icd_pkg::icd_cls_exit, icd_pkg::icd_cls_jump})
           ? 2 : 1) + ip;
    instr_word = w;
    ptr_in_prog = p;
    instr_valid = 1'b1;
    @(posedge sys_clk);
    for (n = 0; n < 16; n++) begin
      @(negedge sys_clk);
      r = xs();
      instr_word = r[13:0];
      skip_taken = r[14];
      ptr_in_prog = r[16:15];
      #1;
      if (n == 0) begin
        `CHK("start", 4'hF, {busy, first_cycle, phase == 2'h0, cycle_start})
        `CHK("class", c, instr_class)
        `CHK("cycles", cyc[1:0], cycles_total)
        `CHK("indirect", ip, indirect_prog)
        `CHK("lit", {w[10:8], w[7:0]}, {lit11[10:8], lit8})
        if (fc) `CHK("faddr", w[6:0], file_addr)
        if (bc) `CHK("dest", w[7], dest_file)
        if (fc && !bc) `CHK("bitnum", w[9:7], bit_num)
        if (ir) `CHK("ptr", pt, ptr_sel)
        if (c == icd_pkg::icd_cls_indirect_move) `CHK("mode", w[1:0], ptr_mode)
      end
      if (n == 1) `CHK("read", fc, file_read_stb)
      if (n == 3) begin
        dd = (bc && w[7]) || c == icd_pkg::icd_cls_bit || (c == icd_pkg::icd_cls_indirect_move && st);
        if (c != icd_pkg::icd_cls_literal) `CHK("fwrite", dd, file_write_stb)
        dd = (bc && !w[7]) || c == icd_pkg::icd_cls_exit ||
             (c == icd_pkg::icd_cls_indirect_move && !st);
        if (c != icd_pkg::icd_cls_literal) `CHK("awrite", dd, acc_write_stb)
        `CHK("padj", c == icd_pkg::icd_cls_indirect_move, ptr_adjust_stb)
        if (sk && skip_taken) cyc++;
      end
      if (instr_ready === 1'b1) break;
    end
    if (n == 16) begin
      n_errors++;
      tally_and_finish();
    end else begin
      `CHK("length", 4 * cyc - 1, n)
      `CHK("total", cyc[1:0], cycles_total)
    end
  endtask
  initial begin
    n_errors = 0;
    compares = 0;
    rng = 32'd44032;
    reset = 1'b1;
    instr_valid = 1'b0;
    skip_taken = 1'b0;
    instr_word = 14'h0000;
    ptr_in_prog = 2'h0;
    repeat (16) @(negedge sys_clk);
    reset = 1'b0;
    for (i = 0; i < 36; i++) run_one(dirs[i % 18], (i < 18) ? 2'h0 : 2'h3);
    for (i = 0; i < 400; i++) run_one(14'(xs() >> 3), rng[1:0]);
    // Reset in mid instruction, then restart at the first edge
    run_one(14'h2800, 2'h0);
    @(negedge sys_clk);
    reset = 1'b1;
    repeat (3) @(negedge sys_clk);
    `CHK("rst idle", 4'hF, {phase, !busy, instr_ready})
    `CHK("rst field", 7'h00, file_addr)
    reset = 1'b0;
    for (i = 0; i < 18; i++) run_one(dirs[i], 2'h3);
    tally_and_finish();
  end
endmodule
